// File: bench/periodic_timer_modes_test.sv
`timescale 1ns/1ps
`include "ptm_map.vh"
module periodic_timer_modes_test;
    logic pclk, presetn, psel, penable, pwrite;
    logic ce = 1'b1;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire pready, pslverr, ext_clock_pin, timer_pin_a, timer_pin_b;
    wire timer_out, timer_out_oe_n, compare_a_flag, period_flag, pin_level;
    wire [31:0] prdata;
    int errors = 0;
    int cmp_count = 0;
    ptm_timer dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .ext_clock_pin(ext_clock_pin), .timer_pin_a(timer_pin_a),
        .timer_pin_b(timer_pin_b), .timer_out(timer_out), .timer_out_oe_n(timer_out_oe_n),
        .compare_a_flag(compare_a_flag), .period_flag(period_flag));
    ptm_pins pins_u (.pclk(pclk), .timer_out(timer_out), .timer_out_oe_n(timer_out_oe_n),
        .ext_clock_pin(ext_clock_pin), .timer_pin_a(timer_pin_a), .timer_pin_b(timer_pin_b),
        .pin_level(pin_level));
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task fail_wait;
        errors++;
        $display("Error at %0t: wait timed out", $time);
        end_of_test();
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 50)
                fail_wait();
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, {24'h00_0000, d}, q, e);
    endtask
    task rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask
    // 0 waits for flag A, 1 for the period flag, 2 for a high pin
    task wait_for(input int sel);
        int n;
        n = 0;
        while (!(sel == 0 ? compare_a_flag === 1'b1 :
                 sel == 1 ? period_flag === 1'b1 : timer_out === 1'b1))
        begin
            n++;
            if (n > 3000)
                fail_wait();
            @(posedge pclk);
        end
    endtask
    task cnt_hi(output int n);
        n = 0;
        repeat (8)
        begin
            @(posedge pclk);
            n += pin_level;
        end
    endtask
    task t_regs;
        logic [31:0] q;
        logic e;
        for (int i = 0; i < 4; i++)
        begin
            rd(`PTM_OFF_CMPA_LO + 12'(4 * i), q);
            chk(q, 0);
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(`PTM_OFF_CMPA_HI + 12'(8 * i), 8'hff);
            rd(`PTM_OFF_CMPA_HI + 12'(8 * i), q);
            chk(q, 3);
        end
        apb(1'b0, 12'h040, 32'h0000_0000, q, e);
        chk(e, 1);
        chk(q, 0);
        $display("t_regs done");
    endtask
    task t_cmp;
        wr(`PTM_OFF_CTRL0, 8'h00);
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_CMPA_HI, 8'h00);
        wr(`PTM_OFF_PER_HI, 8'h00);
        wr(`PTM_OFF_CMPA_LO, 8'h05);
        wr(`PTM_OFF_PER_LO, 8'h02);
        wr(`PTM_OFF_CTRL1, 8'h31);
        wr(`PTM_OFF_CTRL0, 8'h08);
        chk(timer_out, 0);
        wait_for(0);
        repeat (3) @(posedge pclk);
        chk(timer_out, 1);
        chk(period_flag, 0);
        wr(`PTM_OFF_CTRL0, 8'h00);
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_PER_LO, 8'h08);
        wr(`PTM_OFF_CTRL1, 8'h38);
        wr(`PTM_OFF_CTRL0, 8'h08);
        repeat (2) @(posedge pclk);
        chk(timer_out, 1);
        wait_for(1);
        chk(compare_a_flag, 1);
        wr(`PTM_OFF_CTRL0, 8'h00);
        wr(`PTM_OFF_CTRL1, 8'hc0);
        chk(timer_out_oe_n, 1);
        $display("t_cmp done");
    endtask
    task t_pwm;
        int n;
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_PER_LO, 8'h04);
        wr(`PTM_OFF_CMPA_LO, 8'h01);
        wr(`PTM_OFF_CTRL1, 8'ha8);
        wr(`PTM_OFF_CTRL0, 8'h08);
        repeat (4) @(posedge pclk);
        cnt_hi(n);
        chk(n, 2);
        wr(`PTM_OFF_CMPA_LO, 8'h06);
        repeat (4) @(posedge pclk);
        cnt_hi(n);
        chk(n, 8);
        chk({period_flag, compare_a_flag}, 3);
        wr(`PTM_OFF_CTRL0, 8'h00);
        wr(`PTM_OFF_CTRL1, 8'h88);
        wr(`PTM_OFF_CTRL0, 8'h08);
        wr(`PTM_OFF_FLAGS, 8'h03);
        repeat (8) @(posedge pclk);
        chk({timer_out, period_flag}, 1);
        $display("t_pwm done");
    endtask
    task t_pulse;
        logic [31:0] q;
        wr(`PTM_OFF_CTRL0, 8'h00);
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_CMPA_LO, 8'h08);
        wr(`PTM_OFF_CTRL1, 8'hb8);
        pins_u.edge_ext();
        wait_for(2);
        chk(compare_a_flag, 0);
        wait_for(0);
        repeat (3) @(posedge pclk);
        rd(`PTM_OFF_CTRL0, q);
        chk({timer_out, q[3]}, 0);
        $display("t_pulse done");
    endtask
    task t_cap;
        logic [31:0] q;
        wr(`PTM_OFF_CTRL0, 8'h00);
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_PER_LO, 8'h00);
        wr(`PTM_OFF_CTRL1, 8'h42);
        wr(`PTM_OFF_CTRL0, 8'h08);
        repeat (20) @(posedge pclk);
        pins_u.edge_ext();
        wait_for(0);
        rd(`PTM_OFF_CMPA_LO, q);
        chk(q >= 16 && q <= 30, 1);
        wr(`PTM_OFF_CTRL1, 8'h72);
        wr(`PTM_OFF_FLAGS, 8'h03);
        pins_u.edge_ext();
        repeat (4) @(posedge pclk);
        chk(compare_a_flag, 0);
        $display("t_cap done");
    endtask
    task t_hold;
        logic [31:0] q;
        logic [31:0] q2;
        wr(`PTM_OFF_CTRL0, 8'h00);
        rd(`PTM_OFF_CNT_LO, q);
        repeat (5) @(posedge pclk);
        rd(`PTM_OFF_CNT_LO, q2);
        chk(q2, q);
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_PER_LO, 8'h06);
        wr(`PTM_OFF_CTRL0, 8'h08);
        rd(`PTM_OFF_CNT_LO, q);
        chk(q, 0);
        ce <= 1'b0;
        repeat (10) @(posedge pclk);
        ce <= 1'b1;
        rd(`PTM_OFF_CNT_LO, q);
        chk(q, 3);
        wait_for(1);
        rd(`PTM_OFF_CNT_LO, q);
        chk(q < 6, 1);
        chk(compare_a_flag, 0);
        wr(`PTM_OFF_CTRL0, 8'h00);
        wr(`PTM_OFF_CTRL1, 8'h50);
        wr(`PTM_OFF_FLAGS, 8'h03);
        wr(`PTM_OFF_CTRL0, 8'h08);
        pins_u.edge_pin_a();
        @(posedge pclk);
        chk(compare_a_flag, 0);
        @(posedge pclk);
        chk(compare_a_flag, 1);
        $display("t_hold done");
    endtask
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_cmp();
        t_pwm();
        t_pulse();
        t_cap();
        t_hold();
        end_of_test();
    end
endmodule

// File: bench/ptm_pins.sv
`timescale 1ns/1ps
module ptm_pins (
    // Clock and timer pin
    input wire pclk,
    input wire timer_out,
    input wire timer_out_oe_n,
    // Pins driven towards the timer, and the pin level seen by the bench
    output logic ext_clock_pin,
    output logic timer_pin_a,
    output logic timer_pin_b,
    output wire pin_level
);
    // Pull-up holds the pin high once the timer lets go of it
    assign pin_level = timer_out_oe_n ? 1'b1 : timer_out;
    initial
    begin
        ext_clock_pin = 1'b0;
        timer_pin_a = 1'b0;
        timer_pin_b = 1'b0;
    end
    // One short high pulse on the trigger pin
    task edge_ext;
        @(posedge pclk);
        ext_clock_pin <= 1'b1;
        @(posedge pclk);
        ext_clock_pin <= 1'b0;
    endtask
    // One short high pulse on capture pin A
    task edge_pin_a;
        @(posedge pclk);
        timer_pin_a <= 1'b1;
        @(posedge pclk);
        timer_pin_a <= 1'b0;
    endtask
endmodule

// File: bench/ptm_timer_props.sv
`timescale 1ns/1ps
`include "ptm_map.vh"
module ptm_props #(
    parameter CW = 10
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // Pins and flags
    input wire ext_clock_pin,
    input wire timer_pin_a,
    input wire timer_pin_b,
    input wire timer_out,
    input wire timer_out_oe_n,
    input wire compare_a_flag,
    input wire period_flag
);
    logic [7:0] c1_r;
    logic on_r;
    wire wr_acc = psel && penable && pwrite && ce;
    // Software copy of the mode register and counter-on bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c1_r <= 8'h00;
            on_r <= 1'b0;
        end
        else if (wr_acc && paddr == `PTM_OFF_CTRL1)
            c1_r <= pwdata[7:0];
        else if (wr_acc && paddr == `PTM_OFF_CTRL0)
            on_r <= pwdata[`PTM_C0_ON];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_oe; timer_out_oe_n == c1_r[6]; endproperty
    a_oe: assert property (p_oe) else $error("pin enable wrong for mode");
    property p_rdhi;
        psel && penable && !pwrite && (paddr == 12'h014 || paddr == 12'h01C)
        |-> prdata[31:2] == 0;
    endproperty
    a_rdhi: assert property (p_rdhi) else $error("high byte upper bits set");
    property p_pflag; c1_r[7] == c1_r[6] && c1_r[0] |=> !$rose(period_flag); endproperty
    a_pflag: assert property (p_pflag) else $error("period flag with clear select");
    property p_init;
        wr_acc && paddr == `PTM_OFF_CTRL0 && pwdata[3] && !on_r && c1_r[7:6] == 2'b00
        |-> ##[2:4] timer_out == (c1_r[3] ^ c1_r[2]);
    endproperty
    a_init: assert property (p_init) else $error("initial level not loaded");
    property p_force; (c1_r[7:4] == 4'b1000 && !c1_r[2] && on_r)[*3] |-> timer_out == !c1_r[3];
    endproperty
    a_force: assert property (p_force) else $error("forced inactive level wrong");
    property p_pend;
        c1_r[7:4] == 4'b1011 && $rose(compare_a_flag)
        |-> ##[0:2] timer_out == !(c1_r[3] ^ c1_r[2]);
    endproperty
    a_pend: assert property (p_pend) else $error("pulse did not end");
    property p_capoff; c1_r[7:4] == 4'b0111 |=> !$rose(compare_a_flag); endproperty
    a_capoff: assert property (p_capoff) else $error("capture while disabled");
    property p_trig;
        c1_r[7:4] == 4'b1011 && $rose(ext_clock_pin)
        |-> ##[1:8] timer_out == (c1_r[3] ^ c1_r[2]);
    endproperty
    a_trig: assert property (p_trig) else $error("pin edge gave no pulse");
    c_flag: cover property ($rose(compare_a_flag));
    c_pwm: cover property (c1_r[7:4] == 4'b1010 && on_r);
    c_cap: cover property (c1_r[7:6] == 2'b01 && $rose(compare_a_flag));
endmodule
bind ptm_timer ptm_props #(.CW(CW)) props_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .ext_clock_pin(ext_clock_pin), .timer_pin_a(timer_pin_a),
    .timer_pin_b(timer_pin_b), .timer_out(timer_out), .timer_out_oe_n(timer_out_oe_n),
    .compare_a_flag(compare_a_flag), .period_flag(period_flag)
);

// File: hdl/ptm_map.vh
// What this block does
// - Mode 00 selects compare match output
// - Clear-select low: period match clears, both flags
// - Clear-select high: compare A clears, A flag only
// - Compare A match flag alone changes pin
// - Counter-on rise loads pin initial level
// - Mode 11 timer, same flags, pin released
// - PWM: period clears, compare A sets duty
// - PWM period is value, zero means 1024
// - Duty at or above period stays active
// - PWM flags both; level and invert bits
// - Functions 00/01 force pin, counting continues
// - External pin edge sets counter-on, pulse starts
// - Compare A match ends pulse, clears on
// - Pulse counter resets only on counter-on rise
// - Mode 01 capture, source selectable, starts on rise
// - Capture edge copies counter into compare A
// - Capture counter free runs, period match wraps
// - Function 11 disables capture, counting continues
// - Ten-bit values split low/high, upper zeros
// - Counter-on rise zeroes counter, fall holds
// - Initial level bit: 0 low, 1 high
`ifndef PTM_MAP_VH
`define PTM_MAP_VH
// Register byte offsets
`define PTM_OFF_CTRL0 12'h000
`define PTM_OFF_CTRL1 12'h004
`define PTM_OFF_CNT_LO 12'h008
`define PTM_OFF_CNT_HI 12'h00C
`define PTM_OFF_CMPA_LO 12'h010
`define PTM_OFF_CMPA_HI 12'h014
`define PTM_OFF_PER_LO 12'h018
`define PTM_OFF_PER_HI 12'h01C
`define PTM_OFF_FLAGS 12'h020
// Control 0 fields
`define PTM_C0_ON 3
// Control 1 fields
`define PTM_C1_CLR 0
`define PTM_C1_CAPS 1
`define PTM_C1_INV 2
`define PTM_C1_OC 3
`define PTM_C1_IO_LSB 4
`define PTM_C1_MODE_LSB 6
// Flag fields
`define PTM_FLG_A 0
`define PTM_FLG_P 1
// Modes
`define PTM_MODE_CMP 2'b00
`define PTM_MODE_CAP 2'b01
`define PTM_MODE_PWM 2'b10
`define PTM_MODE_TMR 2'b11
// Output functions
`define PTM_IO_00 2'b00
`define PTM_IO_01 2'b01
`define PTM_IO_10 2'b10
`define PTM_IO_11 2'b11
// Reset values
`define PTM_RST_BYTE 8'h00
`define PTM_RST_VAL 10'h000
`endif

// File: hdl/ptm_timer.v
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ptm_map.vh"
module ptm_timer #(
    parameter CW = 10
) (
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // Timer pins
    input wire ext_clock_pin,
    input wire timer_pin_a,
    input wire timer_pin_b,
    output reg timer_out,
    output wire timer_out_oe_n,
    // Status
    output wire compare_a_flag,
    output wire period_flag
);

    // Register state
    reg counter_on_r;
    reg on_prev_r;
    reg [1:0] op_mode_r;
    reg [1:0] out_func_r;
    reg out_initial_level_r;
    reg out_invert_r;
    reg capture_source_sel_r;
    reg clear_select_r;
    reg [CW-1:0] compare_a_value_r;
    reg [CW-1:0] period_value_r;
    reg [CW-1:0] cnt_r;
    reg flag_a_r;
    reg flag_p_r;
    reg out_lvl_r;
    reg ext_prev_r;
    reg pa_prev_r;
    reg pb_prev_r;

    // Next values
    reg counter_on_nxt;
    reg [CW-1:0] cnt_nxt;
    reg [CW-1:0] compare_a_nxt;
    reg flag_a_nxt;
    reg flag_p_nxt;
    reg out_lvl_nxt;
    reg timer_out_nxt;
    reg [31:0] rdata_nxt;
    reg pwm_active;

    // Value one below a compare value, wrapping zero to all ones
    function [CW-1:0] last_count;
        input [CW-1:0] v;
        begin
            last_count = v - {{(CW-1){1'b0}}, 1'b1};
        end
    endfunction

    // Rising, falling or both edge select
    function edge_hit;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            case (sel)
                `PTM_IO_00: edge_hit = ~prev & cur;
                `PTM_IO_01: edge_hit = prev & ~cur;
                `PTM_IO_10: edge_hit = prev ^ cur;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    // Bus decode
    wire wr_en = psel & penable & pwrite;
    wire rd_setup = psel & ~penable;
    wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `PTM_OFF_FLAGS);
    wire wr_c0 = wr_en && (paddr == `PTM_OFF_CTRL0);
    wire wr_c1 = wr_en && (paddr == `PTM_OFF_CTRL1);
    wire wr_al = wr_en && (paddr == `PTM_OFF_CMPA_LO);
    wire wr_ah = wr_en && (paddr == `PTM_OFF_CMPA_HI);
    wire wr_pl = wr_en && (paddr == `PTM_OFF_PER_LO);
    wire wr_ph = wr_en && (paddr == `PTM_OFF_PER_HI);
    wire wr_fl = wr_en && (paddr == `PTM_OFF_FLAGS);

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign compare_a_flag = flag_a_r;
    assign period_flag = flag_p_r;

    // Mode decode
    wire m_cmp = (op_mode_r == `PTM_MODE_CMP);
    wire m_tmr = (op_mode_r == `PTM_MODE_TMR);
    wire m_cap = (op_mode_r == `PTM_MODE_CAP);
    wire m_pwm = (op_mode_r == `PTM_MODE_PWM) && (out_func_r != `PTM_IO_11);
    wire m_sp = (op_mode_r == `PTM_MODE_PWM) && (out_func_r == `PTM_IO_11);

    // Pin released in timer and capture modes
    assign timer_out_oe_n = m_tmr | m_cap;

    // Counter events
    wire on_rise = counter_on_r & ~on_prev_r;
    wire running = counter_on_r & ~on_rise;
    wire a_match = running && (cnt_r == last_count(compare_a_value_r));
    wire p_match = running && (cnt_r == last_count(period_value_r));
    wire ext_rise = ~ext_prev_r & ext_clock_pin;
    wire cap_edge = capture_source_sel_r ?
        edge_hit(out_func_r, ext_prev_r, ext_clock_pin) :
        (edge_hit(out_func_r, pa_prev_r, timer_pin_a) |
         edge_hit(out_func_r, pb_prev_r, timer_pin_b));

    always @*
    begin
        counter_on_nxt = counter_on_r;
        cnt_nxt = cnt_r;
        compare_a_nxt = compare_a_value_r;
        flag_a_nxt = flag_a_r;
        flag_p_nxt = flag_p_r;
        out_lvl_nxt = out_lvl_r;
        // Counter zeroed on rise, held while off
        if (on_rise)
        begin
            cnt_nxt = `PTM_RST_VAL;
        end
        else if (running)
        begin
            cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
        if (wr_fl && pwdata[`PTM_FLG_A])
        begin
            flag_a_nxt = 1'b0;
        end
        if (wr_fl && pwdata[`PTM_FLG_P])
        begin
            flag_p_nxt = 1'b0;
        end
        if (m_cmp || m_tmr)
        begin
            if (clear_select_r)
            begin
                if (a_match)
                begin
                    cnt_nxt = `PTM_RST_VAL;
                end
            end
            else if (p_match)
            begin
                cnt_nxt = `PTM_RST_VAL;
                flag_p_nxt = 1'b1;
            end
            if (a_match)
            begin
                flag_a_nxt = 1'b1;
            end
            if (on_rise)
            begin
                out_lvl_nxt = out_initial_level_r;
            end
            else if (a_match)
            begin
                case (out_func_r)
                    `PTM_IO_01: out_lvl_nxt = 1'b0;
                    `PTM_IO_10: out_lvl_nxt = 1'b1;
                    `PTM_IO_11: out_lvl_nxt = ~out_lvl_r;
                    default: out_lvl_nxt = out_lvl_r;
                endcase
            end
        end
        else if (m_pwm)
        begin
            if (p_match)
            begin
                cnt_nxt = `PTM_RST_VAL;
                flag_p_nxt = 1'b1;
            end
            if (a_match)
            begin
                flag_a_nxt = 1'b1;
            end
        end
        else if (m_sp)
        begin
            if (ext_rise)
            begin
                counter_on_nxt = 1'b1;
            end
            if (a_match)
            begin
                counter_on_nxt = 1'b0;
                flag_a_nxt = 1'b1;
            end
        end
        else
        begin
            if (p_match)
            begin
                cnt_nxt = `PTM_RST_VAL;
                flag_p_nxt = 1'b1;
            end
            if (cap_edge)
            begin
                compare_a_nxt = cnt_r;
                flag_a_nxt = 1'b1;
            end
        end
        // Control 0 and compare A writes win over hardware updates of the same bits
        if (wr_c0)
        begin
            counter_on_nxt = pwdata[`PTM_C0_ON];
        end
        if (wr_al)
        begin
            compare_a_nxt[7:0] = pwdata[7:0];
        end
        if (wr_ah)
        begin
            compare_a_nxt[CW-1:8] = pwdata[CW-9:0];
        end
    end

    // Output pin level per mode
    always @*
    begin
        pwm_active = (period_value_r != `PTM_RST_VAL) &&
            (compare_a_value_r >= period_value_r);
        pwm_active = pwm_active | (cnt_r < compare_a_value_r);
        case (op_mode_r)
            `PTM_MODE_CMP: timer_out_nxt = out_lvl_r ^ out_invert_r;
            `PTM_MODE_PWM:
            begin
                if (m_sp)
                begin
                    timer_out_nxt = ~(counter_on_r ^ out_initial_level_r) ^ out_invert_r;
                end
                else
                begin
                    case (out_func_r)
                        `PTM_IO_00: timer_out_nxt = ~out_initial_level_r ^ out_invert_r;
                        `PTM_IO_01: timer_out_nxt = out_initial_level_r ^ out_invert_r;
                        default: timer_out_nxt =
                            ~(pwm_active ^ out_initial_level_r) ^ out_invert_r;
                    endcase
                end
            end
            default: timer_out_nxt = 1'b0;
        endcase
    end

    // Read mux
    always @*
    begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            `PTM_OFF_CTRL0: rdata_nxt[`PTM_C0_ON] = counter_on_r;
            `PTM_OFF_CTRL1: rdata_nxt[7:0] = {op_mode_r, out_func_r, out_initial_level_r,
                out_invert_r, capture_source_sel_r, clear_select_r};
            `PTM_OFF_CNT_LO: rdata_nxt[7:0] = cnt_r[7:0];
            `PTM_OFF_CNT_HI: rdata_nxt[CW-9:0] = cnt_r[CW-1:8];
            `PTM_OFF_CMPA_LO: rdata_nxt[7:0] = compare_a_value_r[7:0];
            `PTM_OFF_CMPA_HI: rdata_nxt[CW-9:0] = compare_a_value_r[CW-1:8];
            `PTM_OFF_PER_LO: rdata_nxt[7:0] = period_value_r[7:0];
            `PTM_OFF_PER_HI: rdata_nxt[CW-9:0] = period_value_r[CW-1:8];
            `PTM_OFF_FLAGS: rdata_nxt[1:0] = {flag_p_r, flag_a_r};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_on_r <= 1'b0;
            on_prev_r <= 1'b0;
            op_mode_r <= `PTM_MODE_CMP;
            out_func_r <= `PTM_IO_00;
            out_initial_level_r <= 1'b0;
            out_invert_r <= 1'b0;
            capture_source_sel_r <= 1'b0;
            clear_select_r <= 1'b0;
            compare_a_value_r <= `PTM_RST_VAL;
            period_value_r <= `PTM_RST_VAL;
            cnt_r <= `PTM_RST_VAL;
            flag_a_r <= 1'b0;
            flag_p_r <= 1'b0;
            out_lvl_r <= 1'b0;
            ext_prev_r <= 1'b0;
            pa_prev_r <= 1'b0;
            pb_prev_r <= 1'b0;
            timer_out <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            counter_on_r <= counter_on_nxt;
            on_prev_r <= counter_on_r;
            cnt_r <= cnt_nxt;
            compare_a_value_r <= compare_a_nxt;
            flag_a_r <= flag_a_nxt;
            flag_p_r <= flag_p_nxt;
            out_lvl_r <= out_lvl_nxt;
            ext_prev_r <= ext_clock_pin;
            pa_prev_r <= timer_pin_a;
            pb_prev_r <= timer_pin_b;
            timer_out <= timer_out_nxt;
            if (wr_c1)
            begin
                op_mode_r <= pwdata[`PTM_C1_MODE_LSB+1:`PTM_C1_MODE_LSB];
                out_func_r <= pwdata[`PTM_C1_IO_LSB+1:`PTM_C1_IO_LSB];
                out_initial_level_r <= pwdata[`PTM_C1_OC];
                out_invert_r <= pwdata[`PTM_C1_INV];
                capture_source_sel_r <= pwdata[`PTM_C1_CAPS];
                clear_select_r <= pwdata[`PTM_C1_CLR];
            end
            if (wr_pl)
            begin
                period_value_r[7:0] <= pwdata[7:0];
            end
            if (wr_ph)
            begin
                period_value_r[CW-1:8] <= pwdata[CW-9:0];
            end
            if (rd_setup)
            begin
                prdata <= rdata_nxt;
            end
        end
    end

endmodule
